// file: verilog/lpm_ctrl.sv
/*
  Low-power mode controller: mode state machine, clock gating outputs
  and AXI4-Lite register slave in one module.
  Assumes the core pulses instruction strobes for one cycle, wake-up
  requests are synchronous to clk_sys, and the bus master keeps AXI rules.
*/
// Chosen here: the register addresses and the AXI4-Lite slave port.
// Summary of operation
// [R01] Five modes, each defined by which of cpu, peripheral, time-base clocks run; active and subactive run all three, differing in oscillator and ADC.
// [R02] Stop with select one in active enters watch; only time-base clock runs.
// [R03] Stop with select zero enters stop; all clocks halt, registers reset.
// [R04] Second port mode register keeps its active-mode value through stop.
// [R05] In stop mode every output pin is placed in high impedance.
// [R06] Subactive runs cpu and peripheral clocks from subsystem oscillator, no ADC.
// [R07] Subactive exists only when the build option enables it.
// [R08] Halt instruction stops cpu clock; reset or any interrupt resumes active.
// [R09] Watch ends on timer A or external interrupt zero; low-speed flag picks target.
// [R10] Stop or halt in subactive goes to watch or active by the two flags.
// [R11] Asynchronous reset returns to active mode with active clock gating.
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_ctrl #(
  parameter bit SUBACTIVE_EN = 1'b1,
  parameter int PORTB_W      = 4
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Core side
  input  wire lpm_pkg::lpm_instr_t  instr,
  input  wire lpm_pkg::lpm_wake_t   wake,
  // Clock gating and pin control
  output lpm_pkg::lpm_gates_t       gates,
  output logic [2:0]                modeOut,
  output logic                      pinsHiZ,
  output logic                      regResetReq,
  output logic [PORTB_W-1:0]        portModeB,
  // AXI4-Lite slave
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  localparam int SETTLE = (`LPM_SETTLE_CYC < 1) ? 1 : `LPM_SETTLE_CYC;
  // Elaboration check on widths
  if (PORTB_W < 1 || PORTB_W > 32) begin : g_bad_w
    $error("PORTB_W must be 1..32");
  end

  lpm_pkg::lpm_mode_t mode_q;
  lpm_pkg::lpm_mode_t mode_d;
  logic               stopSel_q;
  logic               lowSpeed_q;
  logic               direct_q;
  logic [PORTB_W-1:0] portB_q;
  logic [7:0]         settle_q;
  logic               directPend_q;
  logic               sleepReq;

  // Gate pattern for each mode, used for the live update; reset loads a literal
  function automatic lpm_pkg::lpm_gates_t gatesFor(input lpm_pkg::lpm_mode_t m);
    lpm_pkg::lpm_gates_t g;
    g = '{sysOscEn: 1'b1, subOscEn: 1'b1, cpuClkEn: 1'b1, perClkEn: 1'b1,
          tbClkEn: 1'b1, adcEn: 1'b1};                                     // [R01]
    case (m)
      lpm_pkg::MODE_STANDBY: g.cpuClkEn = 1'b0;                            // [R08]
      lpm_pkg::MODE_STOP:    g = lpm_pkg::lpm_gates_t'(6'h10);             // [R03]
      lpm_pkg::MODE_WATCH:                                                 // [R02]
      begin
        g.sysOscEn = 1'b0;
        g.cpuClkEn = 1'b0;
        g.perClkEn = 1'b0;
        g.adcEn    = 1'b0;
      end
      lpm_pkg::MODE_SUBACT:                                                // [R06]
      begin
        g.sysOscEn = 1'b0;
        g.adcEn    = 1'b0;
      end
      default: g = g;
    endcase
    return g;
  endfunction : gatesFor

  assign sleepReq = instr.stopInstr | instr.haltInstr;

  // Mode transitions
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      lpm_pkg::MODE_ACTIVE:
      begin
        if (instr.stopInstr)
        begin
          mode_d = stopSel_q ? lpm_pkg::MODE_WATCH : lpm_pkg::MODE_STOP;   // [R02] [R03]
        end
        else if (instr.haltInstr)
        begin
          mode_d = lpm_pkg::MODE_STANDBY;                                  // [R08]
        end
      end
      lpm_pkg::MODE_STANDBY:
      begin
        if (wake.anyIrq)
        begin
          mode_d = lpm_pkg::MODE_ACTIVE;                                   // [R08]
        end
      end
      lpm_pkg::MODE_STOP: mode_d = mode_q;                                 // Only reset leaves stop
      lpm_pkg::MODE_WATCH:
      begin
        if (wake.timerAIrq | wake.extIrqZero)
        begin
          mode_d = (lowSpeed_q && SUBACTIVE_EN) ? lpm_pkg::MODE_SUBACT     // [R09] [R07]
                                                : lpm_pkg::MODE_ACTIVE;
        end
      end
      lpm_pkg::MODE_SUBACT:
      begin
        // Direct transfer waits out oscillator settling before going active
        if (directPend_q && settle_q == 8'h00)
        begin
          mode_d = lpm_pkg::MODE_ACTIVE;                                   // [R10]
        end
        else if (sleepReq && !directPend_q && !(direct_q && !lowSpeed_q))
        begin
          mode_d = lpm_pkg::MODE_WATCH;                                    // [R10]
        end
      end
      default: mode_d = lpm_pkg::MODE_ACTIVE;
    endcase
  end
  // Mode register; reset lands in active
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q <= lpm_pkg::MODE_ACTIVE;                                      // [R11]
    end
    else
    begin
      mode_q <= mode_d;
    end
  end
  // Direct-transfer settle counter
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      directPend_q <= 1'b0;
      settle_q     <= 8'h00;
    end
    else if (mode_q == lpm_pkg::MODE_SUBACT && sleepReq && direct_q && !lowSpeed_q && !directPend_q)
    begin
      directPend_q <= 1'b1;                                                // [R10]
      settle_q     <= 8'(SETTLE - 1);
    end
    else if (directPend_q && settle_q == 8'h00)
    begin
      directPend_q <= 1'b0;
    end
    else if (directPend_q)
    begin
      settle_q <= settle_q - 8'h01;
    end
  end
  // Outputs registered from the next mode so they track mode_q exactly
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      gates       <= '{sysOscEn: 1'b1, subOscEn: 1'b1, cpuClkEn: 1'b1, perClkEn: 1'b1,
                       tbClkEn: 1'b1, adcEn: 1'b1};                        // [R11]
      modeOut     <= 3'h0;
      pinsHiZ     <= 1'b0;
      regResetReq <= 1'b0;
    end
    else
    begin
      gates       <= gatesFor(mode_d);
      modeOut     <= mode_d;
      pinsHiZ     <= (mode_d == lpm_pkg::MODE_STOP);                       // [R05]
      regResetReq <= (mode_d == lpm_pkg::MODE_STOP);                       // [R03]
    end
  end
  // AXI write path: address and data accepted in either order
  logic        awHave_q;
  logic        wHave_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;
  logic [31:0] laneMask;
  assign doWrite  = awHave_q && wHave_q && !s_axi_bvalid;
  assign laneMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 12'h000;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHave_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q == `LPM_CTRL_OFS || awAddr_q == `LPM_PORTB_OFS ||
                         awAddr_q == `LPM_STAT_OFS) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control bits; direct-transfer flag is set only in subactive and cleared in active
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stopSel_q  <= 1'b0;
      lowSpeed_q <= 1'b0;
      direct_q   <= 1'b0;
    end
    else if (mode_d == lpm_pkg::MODE_STOP)
    begin
      stopSel_q  <= 1'b0;                                                  // [R03]
      lowSpeed_q <= 1'b0;
      direct_q   <= 1'b0;
    end
    else
    begin
      if (doWrite && awAddr_q == `LPM_CTRL_OFS && wStrb_q[0])
      begin
        stopSel_q  <= wData_q[`LPM_CTRL_STOPSEL];
        lowSpeed_q <= wData_q[`LPM_CTRL_LOWSPD] & SUBACTIVE_EN;           // [R07]
        direct_q   <= wData_q[`LPM_CTRL_DIRECT] & (mode_q == lpm_pkg::MODE_SUBACT);
      end
      if (mode_q == lpm_pkg::MODE_ACTIVE)
      begin
        direct_q <= 1'b0;                                                  // Always clear in active
      end
    end
  end

  // Second port mode register survives stop entry
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      portB_q   <= PORTB_W'(`LPM_PORTB_RST);
      portModeB <= PORTB_W'(`LPM_PORTB_RST);
    end
    else
    begin
      if (doWrite && awAddr_q == `LPM_PORTB_OFS)
      begin
        portB_q <= PORTB_W'((32'(portB_q) & ~laneMask) | (wData_q & laneMask)); // [R04]
      end
      portModeB <= portB_q;
    end
  end

  // AXI read path
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `LPM_CTRL_OFS:  s_axi_rdata <= {29'h0, direct_q, lowSpeed_q, stopSel_q};
          `LPM_STAT_OFS:  s_axi_rdata <= {28'h0, directPend_q, 3'(mode_q)};
          `LPM_PORTB_OFS: s_axi_rdata <= 32'(portB_q);
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : lpm_ctrl

// file: verilog/lpm_consts.svh
/*
  Constants of the low-power mode controller: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the controller package users.
*/
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
// Register byte offsets
`define LPM_CTRL_OFS      12'h000
`define LPM_STAT_OFS      12'h004
`define LPM_PORTB_OFS     12'h008
// Control field positions
`define LPM_CTRL_STOPSEL  0
`define LPM_CTRL_LOWSPD   1
`define LPM_CTRL_DIRECT   2
// Reset values
`define LPM_CTRL_RST      32'h0000_0000
`define LPM_PORTB_RST     32'h0000_0000
// Oscillator settling time in ns and its cycle count at the system rate
`define LPM_SETTLE_NS     1000
`define LPM_CLK_MHZ       20
`define LPM_SETTLE_CYC    ((`LPM_SETTLE_NS * `LPM_CLK_MHZ + 999) / 1000)
`endif

// file: verilog/lpm_pkg.sv
/*
  Types of the low-power mode controller.
  Assumes nothing of its surroundings.
*/
package lpm_pkg;
  // Five operating modes
  typedef enum logic [2:0] {
    MODE_ACTIVE  = 3'b000,
    MODE_STANDBY = 3'b001,
    MODE_STOP    = 3'b010,
    MODE_WATCH   = 3'b011,
    MODE_SUBACT  = 3'b100
  } lpm_mode_t;
  // Clock and oscillator gates
  typedef struct packed {
    logic sysOscEn;
    logic subOscEn;
    logic cpuClkEn;
    logic perClkEn;
    logic tbClkEn;
    logic adcEn;
  } lpm_gates_t;
  // Core-side strobes
  typedef struct packed {
    logic stopInstr;
    logic haltInstr;
  } lpm_instr_t;
  // Wake-up sources
  typedef struct packed {
    logic anyIrq;
    logic timerAIrq;
    logic extIrqZero;
  } lpm_wake_t;
endpackage : lpm_pkg

// file: dv/lpm_ctrl_checker.sv
/*
  Checker of the mode controller outputs against the core strobes.
  Assumes it is bound into lpm_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module lpm_ctrl_checker (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rstn,
  // Core side
  input wire lpm_pkg::lpm_instr_t instr,
  input wire lpm_pkg::lpm_wake_t  wake,
  // Mode outputs
  input wire lpm_pkg::lpm_gates_t gates,
  input wire logic [2:0]          modeOut,
  input wire logic                pinsHiZ,
  input wire logic                regResetReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Steps of the stop and halt entries and of the watch wake
  sequence stopEntry;
    (modeOut != 3'h2) ##1 (modeOut == 3'h2);
  endsequence
  sequence haltTaken;
    (modeOut == 3'h0) && instr.haltInstr && !instr.stopInstr;
  endsequence
  sequence watchWake;
    (modeOut == 3'h3) && (wake.timerAIrq || wake.extIrqZero);
  endsequence
  chk_active_gates: assert property (modeOut == 3'h0 |-> gates == 6'h3F)
    else $error("active gating wrong");
  chk_stop_outputs: assert property (modeOut == 3'h2 |-> gates == 6'h10 && pinsHiZ && regResetReq)
    else $error("stop outputs wrong");
  chk_stop_held: assert property (modeOut == 3'h2 |=> modeOut == 3'h2)
    else $error("stop left without reset");
  chk_stop_cause: assert property (stopEntry |-> $past(instr.stopInstr))
    else $error("stop entered without strobe");
  chk_watch_outputs: assert property (modeOut == 3'h3 |-> gates == 6'h12 && !pinsHiZ)
    else $error("watch outputs wrong");
  chk_standby_gates: assert property (modeOut == 3'h1 |-> gates == 6'h37)
    else $error("standby gating wrong");
  chk_sub_gates: assert property (modeOut == 3'h4 |-> gates == 6'h1E)
    else $error("subactive gating wrong");
  chk_halt_entry: assert property (haltTaken |=> modeOut == 3'h1)
    else $error("halt not taken");
  chk_standby_wake: assert property (modeOut == 3'h1 && wake.anyIrq |=> modeOut == 3'h0)
    else $error("standby not ended");
  chk_watch_wake: assert property (watchWake |=> modeOut inside {3'h0, 3'h4})
    else $error("watch not ended");
  chk_mode_legal: assert property (modeOut <= 3'h4)
    else $error("mode code out of range");
  chk_hiz_in_stop: assert property ((pinsHiZ || regResetReq) |-> modeOut == 3'h2)
    else $error("high impedance outside stop");
endmodule : lpm_ctrl_checker

bind lpm_ctrl lpm_ctrl_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .instr(instr), .wake(wake),
  .gates(gates), .modeOut(modeOut), .pinsHiZ(pinsHiZ), .regResetReq(regResetReq));

// file: dv/lpm_core_model.sv
/*
  Processor core model: issues one-cycle instruction and wake strobes.
  Assumes a free-running clk_sys; the bench calls pulse().
*/
`timescale 1ns/1ps
module lpm_core_model (
  // Clock
  input wire logic          clk_sys,
  // Strobes towards the controller
  output lpm_pkg::lpm_instr_t instr,
  output lpm_pkg::lpm_wake_t  wake
);
  // Idle at time zero
  initial
  begin
    instr = '0;
    wake  = '0;
  end
  // One-cycle strobe; a gap of one edge follows so calls never collide
  task automatic pulse(input lpm_pkg::lpm_instr_t i, input lpm_pkg::lpm_wake_t w);
    @(posedge clk_sys);
    instr <= i;
    wake  <= w;
    @(posedge clk_sys);
    instr <= '0;
    wake  <= '0;
  endtask : pulse
endmodule : lpm_core_model

// file: dv/lpm_ctrl_tb.sv
/*
  Testbench of the mode controller: AXI4-Lite master tasks and mode tests.
  Assumes the core model drives strobes and the checker is bound in.
*/
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rstn    = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pinsHiZ, regResetReq;
  logic [3:0]  s_axi_wstrb = 4'hF, portModeB;
  logic [2:0]  modeOut;
  lpm_pkg::lpm_instr_t instr;
  lpm_pkg::lpm_wake_t  wake;
  lpm_pkg::lpm_gates_t gates;
  int failCount = 0;
  int comparisons = 0;
  int waitCnt;
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  lpm_core_model core (.clk_sys, .instr, .wake);
  lpm_ctrl dut (.clk_sys, .rstn, .instr, .wake, .gates, .modeOut, .pinsHiZ, .regResetReq, .portModeB,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Verdict and end of run
  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrapUp
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      failCount++;
    end
  endtask : chk
  // A hung handshake counts as a mismatch and ends the run
  task automatic hung(input int n);
    if (n >= 50)
    begin
      $display("CHECK FAILED handshake expected answer seen none");
      failCount++;
      wrapUp();
    end
  endtask : hung
  // Address and data offered together, each released when taken
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hung(n);
  endtask : axiWr
  task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hung(n);
  endtask : axiRd
  // Mode and gating just after the edge that took the strobe
  task automatic expMode(input logic [2:0] m, input logic [5:0] g);
    #1;
    chk("modeOut", m, modeOut);
    chk("gates", g, gates);
  endtask : expMode
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    expMode(3'h0, 6'h3F);
    axiRd(`LPM_CTRL_OFS, rd, rs);
    chk("ctrl reset", 32'h0000_0000, rd);
    axiWr(12'h00C, 32'h0000_0001, rs);
    chk("unmapped bresp", 2'h2, rs);
    axiRd(12'h00C, rd, rs);
    chk("unmapped rresp", 2'h2, rs);
    $display("Test reset done");
    // Halt is ignored once in standby; any interrupt resumes
    core.pulse(2'h1, 3'h0);
    expMode(3'h1, 6'h37);
    core.pulse(2'h1, 3'h0);
    expMode(3'h1, 6'h37);
    core.pulse(2'h0, 3'h4);
    expMode(3'h0, 6'h3F);
    $display("Test standby done");
    // Stop beats a simultaneous halt; low-speed flag zero wakes to active
    axiWr(`LPM_CTRL_OFS, 32'h0000_0001, rs);
    core.pulse(2'h3, 3'h0);
    expMode(3'h3, 6'h12);
    core.pulse(2'h0, 3'h4);
    expMode(3'h3, 6'h12);
    core.pulse(2'h0, 3'h2);
    expMode(3'h0, 6'h3F);
    $display("Test watch done");
    // Low-speed flag one: watch to subactive, back to watch, then direct transfer
    axiWr(`LPM_CTRL_OFS, 32'h0000_0003, rs);
    core.pulse(2'h2, 3'h0);
    expMode(3'h3, 6'h12);
    core.pulse(2'h0, 3'h1);
    expMode(3'h4, 6'h1E);
    core.pulse(2'h1, 3'h0);
    expMode(3'h3, 6'h12);
    core.pulse(2'h0, 3'h2);
    expMode(3'h4, 6'h1E);
    axiWr(`LPM_CTRL_OFS, 32'h0000_0005, rs);
    axiRd(`LPM_CTRL_OFS, rd, rs);
    chk("direct flag set", 32'h0000_0005, rd);
    core.pulse(2'h2, 3'h0);
    expMode(3'h4, 6'h1E);
    // Settling must last the full count before active returns
    for (waitCnt = 1; waitCnt <= 50; waitCnt++)
    begin
      @(posedge clk_sys);
      #1;
      if (modeOut == 3'h0)
        break;
    end
    hung(waitCnt);
    chk("settle cycles", `LPM_SETTLE_CYC, waitCnt);
    expMode(3'h0, 6'h3F);
    axiRd(`LPM_CTRL_OFS, rd, rs);
    chk("direct flag cleared", 32'h0000_0000, rd & 32'h0000_0004);
    $display("Test subactive done");
    // Stop with select zero clears control bits but keeps the port mode register
    axiWr(`LPM_PORTB_OFS, 32'h0000_000A, rs);
    axiWr(`LPM_CTRL_OFS, 32'h0000_0002, rs);
    core.pulse(2'h2, 3'h0);
    expMode(3'h2, 6'h10);
    chk("pinsHiZ", 1'b1, pinsHiZ);
    chk("regResetReq", 1'b1, regResetReq);
    chk("portModeB", 4'hA, portModeB);
    axiRd(`LPM_CTRL_OFS, rd, rs);
    chk("ctrl cleared in stop", 32'h0000_0000, rd);
    core.pulse(2'h0, 3'h7);
    core.pulse(2'h1, 3'h0);
    expMode(3'h2, 6'h10);
    @(posedge clk_sys);
    rstn <= 1'b0;
    expMode(3'h0, 6'h3F);
    chk("pinsHiZ reset", 1'b0, pinsHiZ);
    chk("portModeB reset", 4'h0, portModeB);
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    core.pulse(2'h1, 3'h0);
    expMode(3'h1, 6'h37);
    $display("Test stop done");
    wrapUp();
  end
endmodule : lpm_ctrl_tb
